// *** design/dsf_top.sv ***
// Status-flag generator: evaluates drive conditions into level flags
// and routes them to two open-collector terminals and the relay.
// Assumes measurements arrive on clk; undervoltage comes from a pin.
`timescale 1ns/10ps
`include "dsf_consts.svh"

module dsf_top (
    input wire logic clk, // 100 MHz system clock
    input wire logic reset, // Synchronous, active high
    input wire logic [`DSF_AW-1:0] reg_addr, // Register index
    input wire logic [`DSF_DW-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [`DSF_DW-1:0] reg_rdata, // Read data, next cycle
    input wire dsf_pkg::dsf_meas_s meas, // Drive measurements
    input wire logic uv_pin, // Undervoltage detector pin
    input wire logic fault_trip, // Trip event pulse
    input wire logic fault_clear, // Fault clear pulse
    output logic [1:0] oc_o, // Open-collector data, always low
    output logic [1:0] oc_oe_n, // Low while terminal is pulled
    output logic relay_on, // Relay coil drive
    output logic irq // Level interrupt
);

    localparam int NOUT = 3;

    logic uv_s1_ff;
    logic uv_s2_ff;
    dsf_pkg::dsf_code_t curve_ff;
    dsf_pkg::dsf_val_t level_ff [4];
    dsf_pkg::dsf_val_t hours_limit_ff;
    dsf_pkg::dsf_val_t heat_level_ff;
    dsf_pkg::dsf_code_t sel_ff [NOUT];
    dsf_pkg::dsf_flags_s flags_ff;
    dsf_pkg::dsf_flags_s nxt_flags;
    logic [`DSF_NFLAG-1:0] prev_ff;
    logic [`DSF_NFLAG-1:0] istat_ff;
    logic [`DSF_NFLAG-1:0] ien_ff;
    logic [NOUT-1:0] nxt_term;
    logic fault_ff;
    logic wr_clr;
    logic slv_mode;
    logic clamp_mode;
    dsf_pkg::dsf_val_t torque_level;

    assign slv_mode = (curve_ff == `DSF_CURVE_SLV);
    assign clamp_mode = (curve_ff == `DSF_CURVE_CLAMP);
    assign torque_level = level_ff[meas.quadrant];
    assign wr_clr = reg_wr && (reg_addr == `DSF_REG_ICLR);

    // Undervoltage pin synchroniser
    always_ff @(posedge clk) begin
        if (reset) begin
            uv_s1_ff <= 1'b0;
            uv_s2_ff <= 1'b0;
        end else begin
            uv_s1_ff <= uv_pin;
            uv_s2_ff <= uv_s1_ff;
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (reset) begin
            curve_ff <= `DSF_RST_CURVE;
            hours_limit_ff <= `DSF_RST_LEVEL;
            heat_level_ff <= `DSF_RST_LEVEL;
            ien_ff <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `DSF_REG_CURVE) begin
                curve_ff <= reg_wdata[`DSF_CW-1:0];
            end else if (reg_addr == `DSF_REG_HOURS) begin
                hours_limit_ff <= reg_wdata[`DSF_VW-1:0];
            end else if (reg_addr == `DSF_REG_HEAT) begin
                heat_level_ff <= reg_wdata[`DSF_VW-1:0];
            end else if (reg_addr == `DSF_REG_IEN) begin
                ien_ff <= reg_wdata[`DSF_NFLAG-1:0];
            end
        end
    end

    // Torque levels, one per operating quadrant
    for (genvar i = 0; i < 4; i++) begin : g_level
        always_ff @(posedge clk) begin
            if (reset) begin
                level_ff[i] <= `DSF_RST_LEVEL;
            end else if (reg_wr && reg_addr == `DSF_REG_TQ0 + 4'(i)) begin
                level_ff[i] <= reg_wdata[`DSF_VW-1:0];
            end
        end
    end

    // Terminal function selections
    for (genvar i = 0; i < NOUT; i++) begin : g_sel
        always_ff @(posedge clk) begin
            if (reset) begin
                sel_ff[i] <= (i == 0) ? `DSF_RST_SEL0 :
                             (i == 1) ? `DSF_RST_SEL1 : `DSF_RST_SEL2;
            end else if (reg_wr && reg_addr == `DSF_REG_SEL0 + 4'(i)) begin
                sel_ff[i] <= reg_wdata[`DSF_CW-1:0];
            end
        end
    end

    // Fault memory: trip sets, clear resets, trip wins
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_ff <= 1'b0;
        end else if (fault_trip) begin
            fault_ff <= 1'b1;
        end else if (fault_clear) begin
            fault_ff <= 1'b0;
        end
    end

    // Flag evaluation
    always_comb begin
        nxt_flags = '0;
        nxt_flags.over_torque = slv_mode &&
            (meas.est_torque > torque_level);
        nxt_flags.low_supply = uv_s2_ff;
        nxt_flags.torque_clamp = clamp_mode && meas.clamp_active;
        nxt_flags.run_over = (meas.run_hours > hours_limit_ff);
        nxt_flags.powered_over =
            (meas.powered_hours > hours_limit_ff);
        nxt_flags.heat_warn =
            (meas.thermal_level > heat_level_ff);
        nxt_flags.fault = fault_ff;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Terminal routing, re-evaluated every cycle
    for (genvar i = 0; i < NOUT; i++) begin : g_route
        always_comb begin
            if (sel_ff[i] == `DSF_FN_OTQ) begin
                nxt_term[i] = flags_ff.over_torque;
            end else if (sel_ff[i] == `DSF_FN_UV) begin
                nxt_term[i] = flags_ff.low_supply;
            end else if (sel_ff[i] == `DSF_FN_CLAMP) begin
                nxt_term[i] = flags_ff.torque_clamp;
            end else if (sel_ff[i] == `DSF_FN_RUN) begin
                nxt_term[i] = flags_ff.run_over;
            end else if (sel_ff[i] == `DSF_FN_PWR) begin
                nxt_term[i] = flags_ff.powered_over;
            end else if (sel_ff[i] == `DSF_FN_HEAT) begin
                nxt_term[i] = flags_ff.heat_warn;
            end else if (sel_ff[i] == `DSF_FN_FAULT) begin
                nxt_term[i] = flags_ff.fault;
            end else begin
                nxt_term[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            oc_o <= 2'h0;
            oc_oe_n <= 2'h3;
            relay_on <= 1'b0;
        end else begin
            oc_o <= 2'h0;
            oc_oe_n <= ~nxt_term[1:0];
            relay_on <= nxt_term[2];
        end
    end

    // Interrupt status: rising flag edges, set wins over clear
    always_ff @(posedge clk) begin
        if (reset) begin
            prev_ff <= '0;
            istat_ff <= '0;
            irq <= 1'b0;
        end else begin
            prev_ff <= flags_ff;
            istat_ff <= (istat_ff & ~(wr_clr ? reg_wdata[`DSF_NFLAG-1:0] :
                         '0)) | (flags_ff & ~prev_ff);
            irq <= |(((istat_ff & ~(wr_clr ? reg_wdata[`DSF_NFLAG-1:0] :
                   '0)) | (flags_ff & ~prev_ff)) & ien_ff);
        end
    end

    // Read port
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == `DSF_REG_CURVE) begin
                reg_rdata <= {24'h000000, curve_ff};
            end else if (reg_addr >= `DSF_REG_TQ0 &&
                         reg_addr < `DSF_REG_HOURS) begin
                reg_rdata <= {16'h0000,
                    level_ff[2'(reg_addr - `DSF_REG_TQ0)]};
            end else if (reg_addr == `DSF_REG_HOURS) begin
                reg_rdata <= {16'h0000, hours_limit_ff};
            end else if (reg_addr == `DSF_REG_HEAT) begin
                reg_rdata <= {16'h0000, heat_level_ff};
            end else if (reg_addr >= `DSF_REG_SEL0 &&
                         reg_addr < `DSF_REG_FLAGS) begin
                reg_rdata <= {24'h000000,
                    sel_ff[2'(reg_addr - `DSF_REG_SEL0)]};
            end else if (reg_addr == `DSF_REG_FLAGS) begin
                reg_rdata <= {25'h0000000, flags_ff};
            end else if (reg_addr == `DSF_REG_ISTAT) begin
                reg_rdata <= {25'h0000000, istat_ff};
            end else if (reg_addr == `DSF_REG_IEN) begin
                reg_rdata <= {25'h0000000, ien_ff};
            end else begin
                reg_rdata <= '0;
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence otq_routed_s;
        sel_ff[0] == `DSF_FN_OTQ && flags_ff.over_torque;
    endsequence

    sequence trip_s;
        fault_trip ##1 fault_ff;
    endsequence

    otq_level_a: assert property (
        slv_mode && meas.est_torque > torque_level |=> flags_ff.over_torque)
        else $error("over-torque flag missed");
    otq_mode_a: assert property (
        !slv_mode |=> !flags_ff.over_torque)
        else $error("over-torque flag outside vector mode");
    otq_route_a: assert property (
        otq_routed_s ##0 $stable(sel_ff[0]) |=> !oc_oe_n[0])
        else $error("over-torque not on terminal one");
    uv_flag_a: assert property (
        $rose(uv_s2_ff) |=> flags_ff.low_supply ##1 flags_ff.low_supply
            or !uv_s2_ff)
        else $error("low-supply flag wrong");
    clamp_flag_a: assert property (
        flags_ff.torque_clamp |-> $past(clamp_mode && meas.clamp_active))
        else $error("torque-clamp flag without cause");
    run_hours_a: assert property (
        meas.run_hours <= hours_limit_ff |=> !flags_ff.run_over)
        else $error("run-hours flag above nothing");
    pwr_hours_a: assert property (
        meas.powered_hours > hours_limit_ff |=> flags_ff.powered_over)
        else $error("powered-hours flag missed");
    heat_warn_a: assert property (
        flags_ff.heat_warn == $past(meas.thermal_level > heat_level_ff))
        else $error("heat warning mismatch");
    term_follow_a: assert property (
        sel_ff[2] == `DSF_FN_FAULT |=> relay_on == $past(flags_ff.fault))
        else $error("relay does not follow flag");
    fault_hold_a: assert property (
        trip_s |-> fault_ff until fault_clear && !fault_trip)
        else $error("fault flag dropped early");
    irq_set_a: assert property (
        (flags_ff & ~prev_ff & ien_ff) != '0 |=> irq)
        else $error("interrupt missed");

    // Further flag, routing and port checks
    otq_clear_a: assert property (
        slv_mode && meas.est_torque <= torque_level |=>
            !flags_ff.over_torque)
        else $error("over-torque flag without cause");
    term2_otq_a: assert property (
        sel_ff[1] == `DSF_FN_OTQ |=>
            oc_oe_n[1] == !$past(flags_ff.over_torque))
        else $error("over-torque not on terminal two");
    uv_clear_a: assert property (
        !uv_s2_ff |=> !flags_ff.low_supply)
        else $error("low-supply flag without cause");
    clamp_set_a: assert property (
        clamp_mode && meas.clamp_active |=> flags_ff.torque_clamp)
        else $error("torque-clamp flag missed");
    clamp_mode_a: assert property (
        !clamp_mode |=> !flags_ff.torque_clamp)
        else $error("torque-clamp flag outside clamp mode");
    run_set_a: assert property (
        meas.run_hours > hours_limit_ff |=> flags_ff.run_over)
        else $error("run-hours flag missed");
    pwr_clear_a: assert property (
        meas.powered_hours <= hours_limit_ff |=> !flags_ff.powered_over)
        else $error("powered-hours flag without cause");
    relay_heat_a: assert property (
        sel_ff[2] == `DSF_FN_HEAT |=> relay_on == $past(flags_ff.heat_warn))
        else $error("heat warning not on relay");
    fault_set_a: assert property (
        fault_trip |=> fault_ff)
        else $error("fault trip not remembered");
    fault_clear_a: assert property (
        fault_clear && !fault_trip |=> !fault_ff)
        else $error("fault clear ignored");
    stat_set_a: assert property (
        (flags_ff & ~prev_ff) != '0 |=> istat_ff != '0)
        else $error("flag edge not latched");
    irq_mask_a: assert property (
        ien_ff == '0 |=> !irq)
        else $error("interrupt while all sources masked");
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside read cycle");

endmodule

// *** design/dsf_consts.svh ***
// Constants for the drive status-flag generator.
// Assumes a single 100 MHz clock and a plain register port.
// How it works
// - Over-torque flag high while estimated torque exceeds the selected level.
// - Function code 07 routes the over-torque flag to a terminal.
// - Over-torque flag only meaningful in sensorless vector curve mode D3.
// - Function code 09 routes the low-supply flag, high during undervoltage.
// - Function code 10 routes the torque-clamp flag, high while limiting.
// - Torque-clamp flag needs curve select 03 plus the torque levels; the code uses curve 03 and meas.clamp_active only.
// - Code 11 flag high while run hours exceed the hours limit.
// - Code 12 flag high while powered hours exceed the same limit.
// - Heat warning high while thermal level exceeds its warning level.
// - Heat warning uses its own threshold, ahead of overload protection.
// - Any flag can go to either open-collector output or the relay.
// - Code 05 fault flag on from a trip until the fault is cleared.
`ifndef DSF_CONSTS_SVH
`define DSF_CONSTS_SVH

`define DSF_AW 4
`define DSF_DW 32
`define DSF_VW 16
`define DSF_CW 8
`define DSF_NFLAG 7

// Register indices on the register port
`define DSF_REG_CURVE 4'h0
`define DSF_REG_TQ0 4'h1
`define DSF_REG_HOURS 4'h5
`define DSF_REG_HEAT 4'h6
`define DSF_REG_SEL0 4'h7
`define DSF_REG_FLAGS 4'hA
`define DSF_REG_ISTAT 4'hB
`define DSF_REG_ICLR 4'hC
`define DSF_REG_IEN 4'hD

// Function option codes
`define DSF_FN_FAULT 8'h05
`define DSF_FN_OTQ 8'h07
`define DSF_FN_UV 8'h09
`define DSF_FN_CLAMP 8'h0A
`define DSF_FN_RUN 8'h0B
`define DSF_FN_PWR 8'h0C
`define DSF_FN_HEAT 8'h0D

// Curve selections
`define DSF_CURVE_CLAMP 8'h03
`define DSF_CURVE_SLV 8'hD3

// Reset values
`define DSF_RST_CURVE 8'h00
`define DSF_RST_LEVEL 16'hFFFF
`define DSF_RST_SEL0 8'h05
`define DSF_RST_SEL1 8'h07
`define DSF_RST_SEL2 8'h05

// Flag bit positions in the flag and interrupt registers
`define DSF_B_OTQ 0
`define DSF_B_UV 1
`define DSF_B_CLAMP 2
`define DSF_B_RUN 3
`define DSF_B_PWR 4
`define DSF_B_HEAT 5
`define DSF_B_FAULT 6

`endif

// *** design/dsf_pkg.sv ***
// Types for the drive status-flag generator.
// Assumes dsf_consts.svh for the widths.
`include "dsf_consts.svh"

package dsf_pkg;
    typedef struct packed {
        logic fault;
        logic heat_warn;
        logic powered_over;
        logic run_over;
        logic torque_clamp;
        logic low_supply;
        logic over_torque;
    } dsf_flags_s;

    typedef logic [`DSF_CW-1:0] dsf_code_t;
    typedef logic [`DSF_VW-1:0] dsf_val_t;

    typedef struct packed {
        dsf_val_t est_torque;
        logic [1:0] quadrant;
        logic clamp_active;
        dsf_val_t run_hours;
        dsf_val_t powered_hours;
        dsf_val_t thermal_level;
    } dsf_meas_s;
endpackage

// *** tb/dsf_term_model.sv ***
// External equipment reading the two open-collector terminals and relay.
// Assumes pull-ups on both terminal lines; relay seen as a plain level.
`timescale 1ns/10ps

module dsf_term_model (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous, active high
    input wire logic [1:0] oc_o, // Terminal data
    input wire logic [1:0] oc_oe_n, // Low while terminal pulled
    input wire logic relay_on, // Relay coil
    input wire logic arrive, // Frequency arrival seen elsewhere
    output logic [1:0] oc_line, // Wire level after pull-up
    output logic relay_closed, // Contact state
    output logic brake_rel // Lift brake released
);
    // Released line floats to the pull-up
    assign oc_line[0] = oc_oe_n[0] ? 1'b1 : oc_o[0];
    assign oc_line[1] = oc_oe_n[1] ? 1'b1 : oc_o[1];
    assign relay_closed = relay_on;

    // Terminal 2 carries over-torque: release on it, engage on arrival
    always_ff @(posedge clk) begin
        if (reset || arrive) begin
            brake_rel <= 1'b0;
        end else if (!oc_line[1]) begin
            brake_rel <= 1'b1;
        end
    end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the status-flag generator.
// Assumes the design header for register indices and function codes.
`timescale 1ns/10ps
`include "dsf_consts.svh"

module tb;
    logic clk, reset, reg_wr, reg_rd, uv_pin, fault_trip, fault_clear;
    logic [`DSF_AW-1:0] reg_addr;
    logic [`DSF_DW-1:0] reg_wdata, reg_rdata;
    dsf_pkg::dsf_meas_s meas;
    logic [1:0] oc_o, oc_oe_n, oc_line;
    logic relay_on, irq, relay_closed, brake_rel, arrive;
    int err_count, tests_run;
    typedef struct packed {
        logic [7:0] curve, code;
        logic [1:0] q;
        logic [15:0] v;
        logic cl, uv, e;
    } dsf_row_s;
    dsf_row_s rows [15] = '{
        '{8'hD3, `DSF_FN_OTQ, 2'h0, 16'h0065, 1'b0, 1'b0, 1'b1},
        '{8'hD3, `DSF_FN_OTQ, 2'h0, 16'h0064, 1'b0, 1'b0, 1'b0},
        '{8'h03, `DSF_FN_OTQ, 2'h0, 16'h00C8, 1'b0, 1'b0, 1'b0},
        '{8'hD3, `DSF_FN_OTQ, 2'h3, 16'h00C8, 1'b0, 1'b0, 1'b0},
        '{8'hD3, `DSF_FN_OTQ, 2'h3, 16'h012D, 1'b0, 1'b0, 1'b1},
        '{8'h00, `DSF_FN_UV, 2'h0, 16'h0000, 1'b0, 1'b1, 1'b1},
        '{8'h00, `DSF_FN_UV, 2'h0, 16'h0000, 1'b0, 1'b0, 1'b0},
        '{8'h03, `DSF_FN_CLAMP, 2'h0, 16'h0000, 1'b1, 1'b0, 1'b1},
        '{8'hD3, `DSF_FN_CLAMP, 2'h0, 16'h0000, 1'b1, 1'b0, 1'b0},
        '{8'h00, `DSF_FN_RUN, 2'h0, 16'h0065, 1'b0, 1'b0, 1'b1},
        '{8'h00, `DSF_FN_RUN, 2'h0, 16'h0064, 1'b0, 1'b0, 1'b0},
        '{8'h00, `DSF_FN_PWR, 2'h0, 16'h0065, 1'b0, 1'b0, 1'b1},
        '{8'h00, `DSF_FN_HEAT, 2'h0, 16'h0051, 1'b0, 1'b0, 1'b1},
        '{8'h00, `DSF_FN_HEAT, 2'h0, 16'h0050, 1'b0, 1'b0, 1'b0},
        '{8'h00, 8'h33, 2'h0, 16'hFFFF, 1'b1, 1'b1, 1'b0}
    };

    dsf_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .meas(meas), .uv_pin(uv_pin),
        .fault_trip(fault_trip), .fault_clear(fault_clear), .oc_o(oc_o),
        .oc_oe_n(oc_oe_n), .relay_on(relay_on), .irq(irq));

    dsf_term_model ext (.clk(clk), .reset(reset), .oc_o(oc_o),
        .oc_oe_n(oc_oe_n), .relay_on(relay_on), .arrive(arrive),
        .oc_line(oc_line), .relay_closed(relay_closed),
        .brake_rel(brake_rel));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask

    task automatic sel_all(input logic [7:0] c);
        wr(`DSF_REG_SEL0, {24'h0, c});
        wr(`DSF_REG_SEL0 + 4'h1, {24'h0, c});
        wr(`DSF_REG_SEL0 + 4'h2, {24'h0, c});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        reset = 1'b1;
        {reg_wr, reg_rd, uv_pin, fault_trip, fault_clear, arrive} = 6'h00;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        meas = '0;
        err_count = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk("reset outputs", {oc_o, oc_oe_n, relay_on, irq}, 6'h0C);
        rd(`DSF_REG_CURVE, 32'h0);
        rd(`DSF_REG_TQ0, 32'hFFFF);
        rd(`DSF_REG_HOURS, 32'hFFFF);
        rd(`DSF_REG_HEAT, 32'hFFFF);
        rd(`DSF_REG_SEL0, 32'h05);
        rd(`DSF_REG_SEL0 + 4'h1, 32'h07);
        rd(`DSF_REG_SEL0 + 4'h2, 32'h05);
        rd(`DSF_REG_IEN, 32'h0);
        wr(`DSF_REG_FLAGS, 32'h7F);
        rd(`DSF_REG_FLAGS, 32'h0);
        rd(4'hF, 32'h0);
        rd(`DSF_REG_ICLR, 32'h0);
        wr(`DSF_REG_TQ0, 32'h0064);
        wr(`DSF_REG_TQ0 + 4'h3, 32'h012C);
        wr(`DSF_REG_HOURS, 32'h0064);
        wr(`DSF_REG_HEAT, 32'h0050);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(`DSF_REG_CURVE, {24'h0, rows[i].curve});
            sel_all(rows[i].code);
            meas <= '{rows[i].v, rows[i].q, rows[i].cl, rows[i].v,
                rows[i].v, rows[i].v};
            uv_pin <= rows[i].uv;
            settle(6);
            chk("terminals", {relay_on, oc_oe_n},
                {3{rows[i].e}} ^ 3'b011);
            chk("oc_line", oc_line, {2{~rows[i].e}});
        end
        $display("test routing done");
        chk("brake released", brake_rel, 1'b1);
        @(posedge clk);
        arrive <= 1'b1;
        @(posedge clk);
        arrive <= 1'b0;
        settle(1);
        chk("brake engaged", brake_rel, 1'b0);
        $display("test brake done");
        sel_all(`DSF_FN_FAULT);
        meas <= '0;
        uv_pin <= 1'b0;
        fault_trip <= 1'b1;
        @(posedge clk);
        fault_trip <= 1'b0;
        settle(10);
        chk("fault held", {relay_on, oc_oe_n}, 3'h4);
        chk("relay_closed", relay_closed, 1'b1);
        @(posedge clk);
        fault_clear <= 1'b1;
        @(posedge clk);
        fault_clear <= 1'b0;
        settle(5);
        chk("fault cleared", {relay_on, oc_oe_n}, 3'h3);
        $display("test fault done");
        wr(`DSF_REG_ICLR, 32'h7F);
        rd(`DSF_REG_ISTAT, 32'h0);
        wr(`DSF_REG_IEN, 32'h1 << `DSF_B_UV);
        uv_pin <= 1'b1;
        for (int k = 0; k < 10 && irq !== 1'b1; k++) @(posedge clk);
        if (irq !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED irq wait expected 1 seen %b", irq);
            finish_test();
        end
        uv_pin <= 1'b0;
        settle(6);
        rd(`DSF_REG_ISTAT, 32'h1 << `DSF_B_UV);
        chk("irq sticky", irq, 1'b1);
        wr(`DSF_REG_IEN, 32'h0);
        settle(3);
        chk("irq masked", irq, 1'b0);
        wr(`DSF_REG_IEN, 32'h1 << `DSF_B_UV);
        settle(3);
        chk("irq unmasked", irq, 1'b1);
        wr(`DSF_REG_ICLR, 32'h1 << `DSF_B_UV);
        settle(3);
        chk("irq cleared", irq, 1'b0);
        rd(`DSF_REG_ISTAT, 32'h0);
        $display("test interrupt done");
        finish_test();
    end
endmodule
